// >>> rtl/ppcs_pkg.sv
// Package of offsets, field positions and reset values for the port registers.
// What this block does
// - Negotiation-disable bit forces speed and duplex.
// - Forced speed bit picks 100 or 10.
// - Forced duplex used when disabled or failed.
// - Five advertisement bits, reset one, gate offers.
// - LED-off bit drives both indicator pins high.
// - Transmit-disable bit stops the port transmitter.
// - Restart bit pulses negotiation, then self-clears.
// - Power-down bit places port in power-down.
// - Crossover-disable bit turns off automatic crossover.
// - Forced MDI bit picks pairs when auto off.
// - Port 1 loopback bit loops inside port MAC.
// - Ports 3 and 4 loopback bit, monitor port 2.
// - Ports 3 and 4 bits 7..1 reserved.
// - Status reports crossover, negotiation done, link good.
// - Status low bits mirror partner advertised abilities.
// - Control 6 at 0x2d and 0x3d, stride sixteen.
// - Control 5 at 0x2c and 0x3c.
package ppcs_pkg;

  // Register byte offsets on the management address space.
  localparam logic [7:0] PPCS_P1_CTRL5_OFS  = 8'h2c;
  localparam logic [7:0] PPCS_P1_CTRL6_OFS  = 8'h2d;
  localparam logic [7:0] PPCS_P1_STAT1_OFS  = 8'h2e;
  localparam logic [7:0] PPCS_P2_CTRL5_OFS  = 8'h3c;
  localparam logic [7:0] PPCS_P2_CTRL6_OFS  = 8'h3d;
  localparam logic [7:0] PPCS_P2_STAT1_OFS  = 8'h3e;
  localparam logic [7:0] PPCS_P3_CTRL6_OFS  = 8'h4d;
  localparam logic [7:0] PPCS_P4_CTRL6_OFS  = 8'h5d;
  localparam logic [7:0] PPCS_PORT_STRIDE   = 8'h10;

  // Control 5 field positions.
  localparam int PPCS_C5_AN_DIS   = 7;
  localparam int PPCS_C5_SPEED    = 6;
  localparam int PPCS_C5_DUPLEX   = 5;
  localparam int PPCS_C5_ADV_HI   = 4;
  localparam int PPCS_C5_ADV_LO   = 0;

  // Control 6 field positions.
  localparam int PPCS_C6_LED_OFF  = 7;
  localparam int PPCS_C6_TX_DIS   = 6;
  localparam int PPCS_C6_RESTART  = 5;
  localparam int PPCS_C6_PWR_DN   = 3;
  localparam int PPCS_C6_MDIX_DIS = 2;
  localparam int PPCS_C6_FRC_MDI  = 1;
  localparam int PPCS_C6_MAC_LPBK = 0;

  // Status 1 field positions.
  localparam int PPCS_S1_MDI      = 7;
  localparam int PPCS_S1_NEGOTIATION_COMPLETE  = 6;
  localparam int PPCS_S1_LINK     = 5;

  // Reset values and writable masks.
  localparam logic [7:0] PPCS_C5_RESET      = 8'h5f;
  localparam logic [7:0] PPCS_C6_RESET      = 8'h00;
  localparam logic [7:0] PPCS_C6_PHY_WMASK  = 8'hef;
  localparam logic [7:0] PPCS_C6_MAC_WMASK  = 8'h01;

endpackage : ppcs_pkg

// >>> rtl/ppcs_phy_port.sv
// One copper port: control 5, control 6 and status 1 registers.
module ppcs_phy_port
  import ppcs_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_c5_wr,
  input  wire logic       i_c6_wr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_mdi_active,
  input  wire logic       i_negotiation_complete,
  input  wire logic       i_link_good,
  input  wire logic [4:0] i_partner_abil,
  input  wire logic       i_led0,
  input  wire logic       i_led1,
  output logic      [7:0] o_c5,
  output logic      [7:0] o_c6,
  output logic      [7:0] o_stat1,
  output logic            o_an_enable,
  output logic            o_speed_100,
  output logic            o_full_duplex,
  output logic      [4:0] o_advertise,
  output logic            o_an_restart,
  output logic            o_tx_disable,
  output logic            o_power_down,
  output logic            o_auto_mdix,
  output logic            o_mdi_select,
  output logic            o_mac_loopback,
  output logic            o_port_indicator_pin_0,
  output logic            o_port_indicator_pin_1
);

  logic [7:0] c5_reg;       // Negotiation forcing and advertisement.
  logic [7:0] c6_reg;       // PHY control; restart bit is never stored.
  logic       restart_reg;  // One-cycle restart pulse to the PHY.

  // Control 5 storage; all eight bits are writable.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      c5_reg <= PPCS_C5_RESET;
    else if (i_c5_wr)
      c5_reg <= i_wdata;
  end

  // Control 6 storage. Restart is masked out so it reads back as zero
  // once the pulse has gone out, which is the self-clearing behaviour.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      c6_reg <= PPCS_C6_RESET;
    else if (i_c6_wr)
      c6_reg <= i_wdata & PPCS_C6_PHY_WMASK & ~(8'h01 << PPCS_C6_RESTART);
  end

  // Restart pulse lasts one cycle after a write of one.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      restart_reg <= 1'b0;
    else
      restart_reg <= i_c6_wr & i_wdata[PPCS_C6_RESTART];
  end

  // Register read views; reserved bit 4 of control 6 stays zero.
  assign o_c5 = c5_reg;
  assign o_c6 = c6_reg;
  // Status is only a live view of PHY state, so writes cannot touch it.
  assign o_stat1 = {i_mdi_active, i_negotiation_complete, i_link_good,
                    i_partner_abil};

  // Speed and duplex resolution toward the PHY.
  assign o_an_enable   = ~c5_reg[PPCS_C5_AN_DIS];
  assign o_speed_100   = c5_reg[PPCS_C5_SPEED];
  assign o_full_duplex = c5_reg[PPCS_C5_DUPLEX];
  assign o_advertise   = c5_reg[PPCS_C5_ADV_HI:PPCS_C5_ADV_LO];
  assign o_an_restart  = restart_reg;

  // Control 6 effects.
  assign o_tx_disable   = c6_reg[PPCS_C6_TX_DIS];
  assign o_power_down   = c6_reg[PPCS_C6_PWR_DN];
  assign o_auto_mdix    = ~c6_reg[PPCS_C6_MDIX_DIS];
  // Forced choice only matters while automatic crossover is off.
  assign o_mdi_select   = c6_reg[PPCS_C6_FRC_MDI];
  assign o_mac_loopback = c6_reg[PPCS_C6_MAC_LPBK];

  // Blanking drives both indicator pins high.
  assign o_port_indicator_pin_0 =
    c6_reg[PPCS_C6_LED_OFF] | i_led0;
  assign o_port_indicator_pin_1 =
    c6_reg[PPCS_C6_LED_OFF] | i_led1;

endmodule : ppcs_phy_port

// >>> rtl/ppcs_regs.sv
// Top of the per-port PHY control and status register bank.
module ppcs_regs
  import ppcs_pkg::*;
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata,
  input  wire logic [1:0] i_mdi_active,
  input  wire logic [1:0] i_negotiation_complete,
  input  wire logic [1:0] i_link_good,
  input  wire logic [9:0] i_partner_abil,
  input  wire logic [1:0] i_led0,
  input  wire logic [1:0] i_led1,
  output logic      [1:0] o_an_enable,
  output logic      [1:0] o_speed_100,
  output logic      [1:0] o_full_duplex,
  output logic      [9:0] o_advertise,
  output logic      [1:0] o_an_restart,
  output logic      [1:0] o_tx_disable,
  output logic      [1:0] o_power_down,
  output logic      [1:0] o_auto_mdix,
  output logic      [1:0] o_mdi_select,
  output logic      [3:0] o_mac_loopback,
  output logic      [1:0] o_port_indicator_pin_0,
  output logic      [1:0] o_port_indicator_pin_1
);

  logic [7:0] c5_v   [2];  // Read views of control 5 per copper port.
  logic [7:0] c6_v   [2];  // Read views of control 6 per copper port.
  logic [7:0] st_v   [2];  // Read views of status 1 per copper port.
  logic [1:0] c5_wr;       // Control 5 write strobes.
  logic [1:0] c6_wr;       // Control 6 write strobes.
  logic       p3_lpbk_reg; // Port 3 MAC loopback, only live bit.
  logic       p4_lpbk_reg; // Port 4 MAC loopback, only live bit.
  logic [7:0] rdata_reg;   // Registered read data.
  logic [1:0] mdi_meta_reg, mdi_sync_reg;   // Crossover sync stages.
  logic [1:0] an_meta_reg,  an_sync_reg;    // Negotiation done sync.
  logic [1:0] lnk_meta_reg, lnk_sync_reg;   // Link good sync.
  logic [9:0] ab_meta_reg,  ab_sync_reg;    // Partner ability sync.

  // Status comes from the analog PHY side; two flops before any use.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      mdi_meta_reg <= 2'h0;
      mdi_sync_reg <= 2'h0;
      an_meta_reg  <= 2'h0;
      an_sync_reg  <= 2'h0;
      lnk_meta_reg <= 2'h0;
      lnk_sync_reg <= 2'h0;
      ab_meta_reg  <= 10'h000;
      ab_sync_reg  <= 10'h000;
    end
    else
    begin
      mdi_meta_reg <= i_mdi_active;
      mdi_sync_reg <= mdi_meta_reg;
      an_meta_reg  <= i_negotiation_complete;
      an_sync_reg  <= an_meta_reg;
      lnk_meta_reg <= i_link_good;
      lnk_sync_reg <= lnk_meta_reg;
      ab_meta_reg  <= i_partner_abil;
      ab_sync_reg  <= ab_meta_reg;
    end
  end

  // Copper port address decode; port 2 sits one stride above port 1.
  always_comb
  begin
    c5_wr[0] = i_wr & (i_addr == PPCS_P1_CTRL5_OFS);
    c5_wr[1] = i_wr & (i_addr == PPCS_P2_CTRL5_OFS);
    c6_wr[0] = i_wr & (i_addr == PPCS_P1_CTRL6_OFS);
    c6_wr[1] = i_wr
             & (i_addr == PPCS_P1_CTRL6_OFS + PPCS_PORT_STRIDE);
  end

  // The two copper ports share one register slice design.
  for (genvar p = 0; p < 2; p++)
  begin : g_port
    ppcs_phy_port u_port (
      .i_ref_clk              (i_ref_clk),
      .i_rst                  (i_rst),
      .i_c5_wr                (c5_wr[p]),
      .i_c6_wr                (c6_wr[p]),
      .i_wdata                (i_wdata),
      .i_mdi_active           (mdi_sync_reg[p]),
      .i_negotiation_complete              (an_sync_reg[p]),
      .i_link_good            (lnk_sync_reg[p]),
      .i_partner_abil         (ab_sync_reg[p*5 +: 5]),
      .i_led0                 (i_led0[p]),
      .i_led1                 (i_led1[p]),
      .o_c5                   (c5_v[p]),
      .o_c6                   (c6_v[p]),
      .o_stat1                (st_v[p]),
      .o_an_enable            (o_an_enable[p]),
      .o_speed_100            (o_speed_100[p]),
      .o_full_duplex          (o_full_duplex[p]),
      .o_advertise            (o_advertise[p*5 +: 5]),
      .o_an_restart           (o_an_restart[p]),
      .o_tx_disable           (o_tx_disable[p]),
      .o_power_down           (o_power_down[p]),
      .o_auto_mdix            (o_auto_mdix[p]),
      .o_mdi_select           (o_mdi_select[p]),
      .o_mac_loopback         (o_mac_loopback[p]),
      .o_port_indicator_pin_0 (o_port_indicator_pin_0[p]),
      .o_port_indicator_pin_1 (o_port_indicator_pin_1[p])
    );
  end

  // MAC-only ports keep just the loopback bit; the rest are reserved.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
    begin
      p3_lpbk_reg <= 1'b0;
      p4_lpbk_reg <= 1'b0;
    end
    else
    begin
      if (i_wr && i_addr == PPCS_P3_CTRL6_OFS)
        p3_lpbk_reg <= i_wdata[PPCS_C6_MAC_LPBK];
      if (i_wr && i_addr == PPCS_P4_CTRL6_OFS)
        p4_lpbk_reg <= i_wdata[PPCS_C6_MAC_LPBK];
    end
  end

  // Port 2 is the monitor port for the port 3 and 4 loopbacks; the switch fabric
  // steers frames accordingly from these enables.
  assign o_mac_loopback[2] = p3_lpbk_reg;
  assign o_mac_loopback[3] = p4_lpbk_reg;

  // Read mux, registered so data is stable one cycle after the strobe.
  // Unmapped offsets return zero.
  always_ff @(posedge i_ref_clk)
  begin
    if (i_rst)
      rdata_reg <= 8'h00;
    else if (i_rd)
    begin
      case (i_addr)
        PPCS_P1_CTRL5_OFS: rdata_reg <= c5_v[0];
        PPCS_P1_CTRL6_OFS: rdata_reg <= c6_v[0];
        PPCS_P1_STAT1_OFS: rdata_reg <= st_v[0];
        PPCS_P2_CTRL5_OFS: rdata_reg <= c5_v[1];
        PPCS_P2_CTRL6_OFS: rdata_reg <= c6_v[1];
        PPCS_P2_STAT1_OFS: rdata_reg <= st_v[1];
        PPCS_P3_CTRL6_OFS: rdata_reg <= {7'h00, p3_lpbk_reg};
        PPCS_P4_CTRL6_OFS: rdata_reg <= {7'h00, p4_lpbk_reg};
        default:           rdata_reg <= 8'h00;
      endcase
    end
  end

  assign o_rdata = rdata_reg;

endmodule : ppcs_regs

// >>> verification/ppcs_regs_chk.sv
// Checker of the register bank port behaviour, bound to the top module.
module ppcs_regs_chk
  import ppcs_pkg::*;
(
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] o_rdata,
  input wire logic [1:0] o_an_enable,
  input wire logic [1:0] o_speed_100,
  input wire logic [1:0] o_full_duplex,
  input wire logic [9:0] o_advertise,
  input wire logic [1:0] o_an_restart,
  input wire logic [1:0] o_tx_disable,
  input wire logic [1:0] o_power_down,
  input wire logic [3:0] o_mac_loopback,
  input wire logic [1:0] o_port_indicator_pin_0
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Writes decoded here on purpose, so a wrong decode in the bank shows.
  wire w2c = i_wr && i_addr == PPCS_P1_CTRL5_OFS;
  wire w3c = i_wr && i_addr == PPCS_P2_CTRL5_OFS;
  wire w2d = i_wr && i_addr == PPCS_P1_CTRL6_OFS;
  wire w3d = i_wr && i_addr == PPCS_P2_CTRL6_OFS;
  wire w4d = i_wr && i_addr == PPCS_P3_CTRL6_OFS;
  a_force_mode: assert property (w2c |=>
    o_an_enable[0] == !$past(i_wdata[7]) && o_speed_100[0] ==
    $past(i_wdata[6]) && o_full_duplex[0] == $past(i_wdata[5]))
    else $error("forced mode mismatch");
  a_adv_port2: assert property (w3c |=>
    o_advertise[9:5] == $past(i_wdata[4:0])) else $error("advertise");
  a_restart_pulse: assert property (w2d && i_wdata[5] |=>
    o_an_restart[0] ##1 !o_an_restart[0]) else $error("restart pulse");
  a_restart_cause: assert property (o_an_restart[1] |->
    $past(w3d && i_wdata[5])) else $error("restart without write");
  a_led_force: assert property (w2d && i_wdata[7] |=>
    o_port_indicator_pin_0[0]) else $error("indicator not forced");
  a_port2_ctrl: assert property (w3d |=>
    o_tx_disable[1] == $past(i_wdata[6]) &&
    o_power_down[1] == $past(i_wdata[3])) else $error("port 2 control");
  a_mac_only: assert property (i_rd &&
    i_addr == PPCS_P4_CTRL6_OFS |=> o_rdata[7:1] == 7'h00)
    else $error("reserved bits read back");
  a_loop_port3: assert property (w4d |=>
    o_mac_loopback[2] == $past(i_wdata[0])) else $error("port 3 loop");
  a_unmapped_read: assert property (i_rd && i_addr == 8'h2f |=>
    o_rdata == 8'h00) else $error("unmapped read not zero");
  c_restart: cover property (o_an_restart[1]);
  c_loop: cover property (o_mac_loopback[3]);
  c_led: cover property (w2d && i_wdata[7]);
endmodule : ppcs_regs_chk

bind ppcs_regs ppcs_regs_chk u_chk (.i_ref_clk, .i_rst, .i_wr, .i_rd,
  .i_addr, .i_wdata, .o_rdata, .o_an_enable, .o_speed_100, .o_full_duplex,
  .o_advertise, .o_an_restart, .o_tx_disable, .o_power_down,
  .o_mac_loopback, .o_port_indicator_pin_0);

// >>> verification/ppcs_phy_model.sv
// Behavioural PHY and link partner that feed the status inputs.
module ppcs_phy_model #(
  parameter int         DLY  = 6,        // Negotiation time in cycles.
  parameter logic [9:0] ABIL = 10'h2b3   // Partner offers, both ports.
)
(
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [1:0] i_an_restart,
  input  wire logic [1:0] i_power_down,
  output logic      [1:0] o_negotiation_complete,
  output logic      [1:0] o_mdi_active,
  output logic      [1:0] o_led,
  output logic      [9:0] o_abil
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_reg [2]; // Cycles since negotiation began, per port.
  // A restart or power-down drops the link and starts counting again.
  always_ff @(posedge i_ref_clk)
    for (int p = 0; p < 2; p++)
      if (i_rst || i_an_restart[p] || i_power_down[p])
        cnt_reg[p] <= 8'h00;
      else if (cnt_reg[p] != 8'(DLY))
        cnt_reg[p] <= cnt_reg[p] + 8'h01;
  assign o_negotiation_complete = {cnt_reg[1] == 8'(DLY), cnt_reg[0] == 8'(DLY)};
  // Only port 2 settles in straight pairs, so both crossover states occur.
  assign o_mdi_active = o_negotiation_complete & 2'b10;
  assign o_led = ~o_negotiation_complete; // Lit low while the link is up.
  // Partner offers are only known once negotiation is done.
  assign o_abil = {{5{o_negotiation_complete[1]}}, {5{o_negotiation_complete[0]}}} & ABIL;
endmodule : ppcs_phy_model

// >>> verification/ppcs_regs_tb.sv
// Self-checking bench for the port register bank.
module ppcs_regs_tb
  import ppcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       i_ref_clk, i_rst, i_wr, i_rd;
  logic [7:0] i_addr, i_wdata, o_rdata;
  logic [7:0] sv; // Last status seen by the polling loops.
  logic [1:0] i_mdi_active, i_negotiation_complete, i_led0, o_an_enable, o_speed_100;
  logic [1:0] o_full_duplex, o_an_restart, o_tx_disable, o_power_down;
  logic [1:0] o_auto_mdix, o_mdi_select, o_port_indicator_pin_0;
  logic [1:0] o_port_indicator_pin_1;
  logic [9:0] i_partner_abil, o_advertise;
  logic [3:0] o_mac_loopback;
  int         fail_count = 0, n_compared = 0, k;
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end
  // Link and LED lines both follow the negotiation state in this model.
  ppcs_regs uut (.i_ref_clk, .i_rst, .i_wr, .i_rd, .i_addr, .i_wdata,
    .o_rdata, .i_mdi_active, .i_negotiation_complete, .i_link_good(i_negotiation_complete),
    .i_partner_abil, .i_led0, .i_led1(i_led0), .o_an_enable, .o_speed_100,
    .o_full_duplex, .o_advertise, .o_an_restart, .o_tx_disable,
    .o_power_down, .o_auto_mdix, .o_mdi_select, .o_mac_loopback,
    .o_port_indicator_pin_0, .o_port_indicator_pin_1);
  ppcs_phy_model phy (.i_ref_clk, .i_rst, .i_an_restart(o_an_restart),
    .i_power_down(o_power_down), .o_negotiation_complete(i_negotiation_complete),
    .o_mdi_active(i_mdi_active), .o_led(i_led0), .o_abil(i_partner_abil));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Strobes are raised and dropped on falling edges, one cycle wide.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_ref_clk);
    i_wr = 1'b1;
    i_addr = a;
    i_wdata = d;
    @(negedge i_ref_clk);
    i_wr = 1'b0;
  endtask : wr
  // Plain read; the data is taken while it stands after the strobe.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge i_ref_clk);
    i_rd = 1'b1;
    i_addr = a;
    @(negedge i_ref_clk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask : rd
  // Read and compare against a value fixed by the caller.
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({2'b00, d}, {2'b00, exp});
  endtask : rc
  task automatic give_verdict;
    if (fail_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict
  initial
  begin
    i_rst = 1'b1;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 8'h00;
    i_wdata = 8'h00;
    repeat (4) @(negedge i_ref_clk);
    i_rst = 1'b0;
    rc(PPCS_P1_CTRL5_OFS, 8'h5f);
    rc(PPCS_P3_CTRL6_OFS, 8'h00);
    chk({o_an_enable, o_speed_100, o_full_duplex, o_auto_mdix},
      10'h0f3);
    wr(PPCS_P1_CTRL5_OFS, 8'h80);
    chk({o_an_enable[0], o_speed_100[0], o_advertise[4:0]},
      10'h000);
    wr(PPCS_P2_CTRL5_OFS, 8'h25);
    chk({o_full_duplex[1], o_advertise[9:5]}, 10'h025);
    rc(PPCS_P2_CTRL5_OFS, 8'h25);
    wr(PPCS_P1_CTRL6_OFS, 8'hff);
    chk(o_an_restart, 10'h001);
    chk({o_tx_disable[0], o_power_down[0], o_auto_mdix[0]},
      10'h006);
    chk({o_mdi_select[0], o_port_indicator_pin_1[0]},
      10'h003);
    rc(PPCS_P1_CTRL6_OFS, 8'hcf);
    wr(PPCS_P3_CTRL6_OFS, 8'hff);
    wr(PPCS_P4_CTRL6_OFS, 8'hff);
    chk(o_mac_loopback, 10'h00d);
    rc(PPCS_P4_CTRL6_OFS, 8'h01);
    wr(8'h2f, 8'hff);
    rc(8'h2f, 8'h00);
    wr(PPCS_P2_CTRL6_OFS, 8'h20);
    chk(o_an_restart, 10'h002);
    // Restart first drops the completion bit, then it returns. Status
    // lags two sync edges, so the first read may still be stale. Both
    // polls are bounded; a spent bound leaves a failing compare.
    k = 0;
    sv = 8'hff;
    while (sv[6] !== 1'b0 && k < 50)
    begin
      rd(PPCS_P2_STAT1_OFS, sv);
      k++;
    end
    chk({9'h000, sv[6]}, 10'h000);
    k = 0;
    while (sv[6] !== 1'b1 && k < 50)
    begin
      rd(PPCS_P2_STAT1_OFS, sv);
      k++;
    end
    chk({9'h000, sv[6]}, 10'h001);
    wr(PPCS_P2_STAT1_OFS, 8'h00);
    rc(PPCS_P2_STAT1_OFS, 8'hf5);
    rc(PPCS_P1_STAT1_OFS, 8'h00);
    wr(PPCS_P2_CTRL6_OFS, 8'h80);
    chk({o_port_indicator_pin_0[1], o_port_indicator_pin_1[1]},
      10'h003);
    wr(PPCS_P2_CTRL6_OFS, 8'h00);
    chk({o_port_indicator_pin_0[1], o_port_indicator_pin_1[1]},
      10'h000);
    give_verdict();
  end
endmodule : ppcs_regs_tb
